// ===== pkg/clock_request_decoder_consts.svh
`ifndef CLOCK_REQUEST_DECODER_CONSTS_SVH
`define CLOCK_REQUEST_DECODER_CONSTS_SVH

// Timing at the 25 MHz system clock.
`define CRD_CLK_PERIOD_NS   40
`define CRD_SPIKE_NS        300
`define CRD_MIN_PULSE_NS    500
`define CRD_FILT_CYCLES \
  ((`CRD_SPIKE_NS + `CRD_CLK_PERIOD_NS - 1) / `CRD_CLK_PERIOD_NS)
`define CRD_MIN_PULSE_CYCLES \
  ((`CRD_MIN_PULSE_NS + `CRD_CLK_PERIOD_NS - 1) / `CRD_CLK_PERIOD_NS)
`define CRD_FILT_W          4
`define CRD_FILT_LAST       4'(`CRD_FILT_CYCLES - 1)
`define CRD_FILT_ZERO       4'h0
`define CRD_FILT_ONE        4'h1

// Configuration byte indices.
`define CRD_BYTE_POL        2'h0
`define CRD_BYTE_SW         2'h1
`define CRD_BYTE_PRIO       2'h2

// Field positions.
`define CRD_NIB_LSB         0
`define CRD_NIB_MSB         3
`define CRD_MODE_LSB        4
`define CRD_MODE_MSB        5
`define CRD_REG_OVR_EN_BIT  4
`define CRD_REG_OVR_VAL_BIT 5

// Reset values.
`define CRD_POL_RST         8'h00
`define CRD_SW_RST          8'h09
`define CRD_PRIO_RST        8'h09
`define CRD_OUT14_MASK      4'h9
`define CRD_SYNC4_RST       4'h0
`define CRD_SYNC3_RST       3'h0

`endif

// ===== pkg/clock_request_pkg.sv
package clock_request_pkg;

  typedef enum logic [1:0] {
    MODE_WIRED_OR  = 2'h0,
    MODE_WIRED_AND = 2'h1,
    MODE_PUSH_PULL = 2'h2
  } mreq_mode_t;

  typedef struct packed {
    logic       en;
    logic [1:0] idx;
    logic [7:0] data;
  } cfg_write_t;

  typedef struct packed {
    logic battery;
    logic core;
    logic buffer;
  } supply_t;

  typedef struct packed {
    logic hiz;
    logic pass;
  } sine_ctl_t;

  typedef struct packed {
    logic                  sync1;
    logic                  sync2;
    logic                  active;
    logic [3:0]            cnt;
  } filt_state_t;

  typedef struct packed {
    logic [3:0]            req_s1;
    logic [3:0]            req_s2;
    supply_t               sup_s1;
    supply_t               sup_s2;
    logic [7:0]            pol_byte;
    logic [7:0]            sw_byte;
    logic [7:0]            prio_byte;
    sine_ctl_t [3:0]       sine;
    logic [3:0]            eff;
    logic                  any_req;
    logic                  mreq_o;
    logic                  mreq_oe;
    logic                  reg_on;
    logic                  blocked;
  } dec_state_t;

endpackage : clock_request_pkg

// ===== src/clock_request_decoder.sv
//
// Notes on behaviour
// - While peripheral reset is low outputs one and four are forced on; otherwise each output follows its pin or, when its priority bit is set, its software bit.
// - Peripheral reset returns the priority and software bits of outputs one and four to their on defaults and leaves every other software bit alone.
// - While peripheral reset is active every configuration write is ignored.
// - The reset driver holds reset low at least 500 ns, and the device filters out spikes of about 300 ns.
// - Priority bits 0 to 3 of configuration byte 2 choose pin or software control per output.
// - Bits 0 to 3 of configuration byte 0 set the active polarity of each request pin.
// - An output with an active request passes the clock, otherwise it is disabled and parked high.
// - The combined request to the master clock is high when any request is active and low only when none is.
// - Under decoder control the regulator is on when any request or peripheral reset is active and off only when neither is.
// - Bits 4 and 5 of configuration byte 2 let software override the regulator decision.
// - The regulator is enabled only with battery and core supplies present and a request, peripheral reset or override value of 1 active.
// - After power-up outputs one and four are on and outputs two and three follow their pins.
// - Core power-up returns every configuration and control bit to its default.
// - With the buffer supply absent all four sine outputs are high impedance.
// - The combined request pin defaults to open-source wired-OR and can be set to wired-AND or push-pull.
`timescale 1ns/10ps
`include "clock_request_decoder_consts.svh"

module clock_request_decoder (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic [3:0]                     peripheral_clock_request,
  input  wire logic                           preset_n_pin,
  input  wire clock_request_pkg::supply_t     supply_pins,
  input  wire clock_request_pkg::cfg_write_t  cfg_wr,
  output clock_request_pkg::sine_ctl_t [3:0]  sine_ctl,
  output logic                                mclk_request_o,
  output logic                                mclk_request_oe,
  output logic                                oscillator_regulator_out,
  output logic [3:0]                          effective_request,
  output logic                                cfg_blocked
);

  clock_request_pkg::dec_state_t s_r;
  clock_request_pkg::dec_state_t s_nxt;
  logic                          preset_active;

  reset_glitch_filter u_filter (
    .clk           (clk),
    .resetn        (resetn),
    .preset_n_pin  (preset_n_pin),
    .preset_active (preset_active)
  );

  // A set polarity bit makes the pin active low.
  function automatic logic [3:0] pin_active(input logic [3:0] pin,
                                            input logic [3:0] pol);
    pin_active = pin ^ pol;
  endfunction : pin_active

  function automatic logic [7:0] force_nibble(input logic [7:0] b,
                                              input logic [3:0] m);
    force_nibble = {b[7:4], b[3:0] | m};
  endfunction : force_nibble

  logic [3:0]                    hw_act;
  logic [3:0]                    sel_req;
  logic [3:0]                    out_req;
  logic                          decoder_on;
  clock_request_pkg::mreq_mode_t mode;

  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.req_s1 = peripheral_clock_request;
    s_nxt.req_s2 = s_r.req_s1;
    s_nxt.sup_s1 = supply_pins;
    s_nxt.sup_s2 = s_r.sup_s1;

    hw_act = pin_active(s_r.req_s2,
                        s_r.pol_byte[`CRD_NIB_MSB:`CRD_NIB_LSB]);
    // Software bit wins over the pin wherever the priority bit is set.
    sel_req = (s_r.prio_byte[`CRD_NIB_MSB:`CRD_NIB_LSB] &
               s_r.sw_byte[`CRD_NIB_MSB:`CRD_NIB_LSB]) |
              (~s_r.prio_byte[`CRD_NIB_MSB:`CRD_NIB_LSB] & hw_act);
    out_req = sel_req;
    if (preset_active)
    begin
      out_req = sel_req | `CRD_OUT14_MASK;
    end

    for (int i = 0; i < 4; i++)
    begin
      s_nxt.sine[i].pass = out_req[i];
      s_nxt.sine[i].hiz  = ~s_r.sup_s2.buffer;
    end
    s_nxt.eff     = out_req;
    s_nxt.any_req = |out_req;

    // Reset keeps the regulator up so a peripheral coming out of reset
    // finds its oscillator already running.
    decoder_on = (|out_req) | preset_active;
    if (s_r.prio_byte[`CRD_REG_OVR_EN_BIT])
    begin
      decoder_on = s_r.prio_byte[`CRD_REG_OVR_VAL_BIT];
    end
    s_nxt.reg_on = decoder_on & s_r.sup_s2.battery &
                   s_r.sup_s2.core;

    mode = clock_request_pkg::mreq_mode_t'(
             s_r.sw_byte[`CRD_MODE_MSB:`CRD_MODE_LSB]);
    unique case (mode)
      clock_request_pkg::MODE_WIRED_AND:
      begin
        s_nxt.mreq_o  = 1'b0;
        s_nxt.mreq_oe = ~(|out_req);
      end
      clock_request_pkg::MODE_PUSH_PULL:
      begin
        s_nxt.mreq_o  = |out_req;
        s_nxt.mreq_oe = 1'b1;
      end
      clock_request_pkg::MODE_WIRED_OR:
      begin
        s_nxt.mreq_o  = 1'b1;
        s_nxt.mreq_oe = |out_req;
      end
      default:
      begin
        // The fourth code is not defined; it falls back to wired-OR.
        s_nxt.mreq_o  = 1'b1;
        s_nxt.mreq_oe = |out_req;
      end
    endcase

    s_nxt.blocked = preset_active;
    if (preset_active)
    begin
      s_nxt.sw_byte   = force_nibble(s_r.sw_byte, `CRD_OUT14_MASK);
      s_nxt.prio_byte = force_nibble(s_r.prio_byte,
                                     `CRD_OUT14_MASK);
    end
    else if (cfg_wr.en)
    begin
      unique case (cfg_wr.idx)
        `CRD_BYTE_POL:  s_nxt.pol_byte  = cfg_wr.data;
        `CRD_BYTE_SW:   s_nxt.sw_byte   = cfg_wr.data;
        `CRD_BYTE_PRIO: s_nxt.prio_byte = cfg_wr.data;
        default:        s_nxt.pol_byte  = s_r.pol_byte;
      endcase
    end
  end

  // Core power-up is the asynchronous reset; every bit returns to default.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r.req_s1    <= `CRD_SYNC4_RST;
      s_r.req_s2    <= `CRD_SYNC4_RST;
      s_r.sup_s1    <= `CRD_SYNC3_RST;
      s_r.sup_s2    <= `CRD_SYNC3_RST;
      s_r.pol_byte  <= `CRD_POL_RST;
      s_r.sw_byte   <= `CRD_SW_RST;
      s_r.prio_byte <= `CRD_PRIO_RST;
      for (int i = 0; i < 4; i++)
      begin
        s_r.sine[i].hiz  <= 1'b1;
        s_r.sine[i].pass <= 1'b0;
      end
      s_r.eff       <= `CRD_SYNC4_RST;
      s_r.any_req   <= 1'b0;
      s_r.mreq_o    <= 1'b1;
      s_r.mreq_oe   <= 1'b0;
      s_r.reg_on    <= 1'b0;
      s_r.blocked   <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign sine_ctl                 = s_r.sine;
  assign mclk_request_o           = s_r.mreq_o;
  assign mclk_request_oe          = s_r.mreq_oe;
  assign oscillator_regulator_out = s_r.reg_on;
  assign effective_request        = s_r.eff;
  assign cfg_blocked              = s_r.blocked;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);

  force_one_four_a : assert property (
    preset_active |=> s_r.sine[0].pass && s_r.sine[3].pass)
    else $error("Outputs one and four not forced on under reset.");

  sw_select_a : assert property (
    !preset_active && s_r.prio_byte[1] |=>
      s_r.sine[1].pass == $past(s_r.sw_byte[1]))
    else $error("Output two ignores its software bit.");

  pin_polarity_a : assert property (
    !preset_active && !s_r.prio_byte[2] |=>
      s_r.sine[2].pass == ($past(s_r.req_s2[2]) ^ $past(s_r.pol_byte[2])))
    else $error("Output three does not follow its pin polarity.");

  reset_defaults_a : assert property (
    preset_active |=> (s_r.sw_byte[3:0] & `CRD_OUT14_MASK) ==
      `CRD_OUT14_MASK && (s_r.prio_byte[3:0] & `CRD_OUT14_MASK) ==
      `CRD_OUT14_MASK && s_r.sw_byte[2:1] == $past(s_r.sw_byte[2:1]))
    else $error("Reset defaults for outputs one and four wrong.");

  write_block_a : assert property (
    preset_active && cfg_wr.en |=> $stable(s_r.pol_byte) &&
      s_r.sw_byte[7:4] == $past(s_r.sw_byte[7:4]))
    else $error("Configuration write accepted during reset.");

  // The drive mode is judged from the byte the outputs were computed from.
  mreq_any_a : assert property (
    $past(s_r.sw_byte[`CRD_MODE_MSB:`CRD_MODE_LSB]) ==
      clock_request_pkg::MODE_PUSH_PULL |->
      mclk_request_o == (|s_r.eff) && mclk_request_oe &&
      s_r.any_req == (|s_r.eff))
    else $error("Combined request disagrees with output requests.");

  wired_and_a : assert property (
    $past(s_r.sw_byte[`CRD_MODE_MSB:`CRD_MODE_LSB]) ==
      clock_request_pkg::MODE_WIRED_AND |->
      mclk_request_oe == !s_r.any_req && !mclk_request_o)
    else $error("Wired-AND drive does not follow the request.");

  wired_or_a : assert property (
    $past(s_r.sw_byte[5:4]) == clock_request_pkg::MODE_WIRED_OR |->
      mclk_request_oe == s_r.any_req && mclk_request_o)
    else $error("Wired-OR drive does not follow the request.");

  sequence no_supply_s;
    !s_r.sup_s2.battery || !s_r.sup_s2.core;
  endsequence

  regulator_gate_a : assert property (
    no_supply_s |=> !oscillator_regulator_out)
    else $error("Regulator on without battery and core supplies.");

  regulator_decoder_a : assert property (
    s_r.sup_s2.battery && s_r.sup_s2.core &&
      !s_r.prio_byte[`CRD_REG_OVR_EN_BIT] &&
      preset_active |=> oscillator_regulator_out)
    else $error("Regulator off while reset is active.");

  regulator_override_a : assert property (
    s_r.sup_s2.battery && s_r.sup_s2.core &&
      s_r.prio_byte[`CRD_REG_OVR_EN_BIT] |=>
      oscillator_regulator_out ==
        $past(s_r.prio_byte[`CRD_REG_OVR_VAL_BIT]))
    else $error("Regulator override not honoured.");

  buffer_hiz_a : assert property (
    !s_r.sup_s2.buffer |=> s_r.sine[0].hiz && s_r.sine[1].hiz &&
      s_r.sine[2].hiz && s_r.sine[3].hiz)
    else $error("Sine outputs driven without buffer supply.");

endmodule : clock_request_decoder

// ===== src/reset_glitch_filter.sv
`timescale 1ns/10ps
`include "clock_request_decoder_consts.svh"

module reset_glitch_filter (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic preset_n_pin,
  output logic      preset_active
);

  clock_request_pkg::filt_state_t s_r;
  clock_request_pkg::filt_state_t s_nxt;

  // The level moves only after the synchronised pin has disagreed with it
  // for a whole filter window, so short spikes in either direction vanish.
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.sync1 = preset_n_pin;
    s_nxt.sync2 = s_r.sync1;
    if (s_r.sync2 == s_r.active)
    begin
      if (s_r.cnt == `CRD_FILT_LAST)
      begin
        s_nxt.active = ~s_r.active;
        s_nxt.cnt    = `CRD_FILT_ZERO;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + `CRD_FILT_ONE;
      end
    end
    else
    begin
      s_nxt.cnt = `CRD_FILT_ZERO;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r.sync1  <= 1'b1;
      s_r.sync2  <= 1'b1;
      s_r.active <= 1'b0;
      s_r.cnt    <= `CRD_FILT_ZERO;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign preset_active = s_r.active;

  sequence held_low_s;
    (!s_r.sync2) [*8];
  endsequence

  property assert_after_window_p;
    @(posedge clk) disable iff (!resetn)
    held_low_s ##1 !s_r.sync2 |=> s_r.active;
  endproperty

  filt_accept_a : assert property (assert_after_window_p)
    else $error("Reset held low past the filter window was not taken.");

  filt_reject_a : assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(s_r.active) |-> $past(!s_r.sync2, 1) && $past(!s_r.sync2, 8))
    else $error("Reset became active after a short spike.");

endmodule : reset_glitch_filter

// ===== tb/periph_model.sv
`timescale 1ns/10ps
module periph_model (
  input  wire logic       clk,
  input  wire logic [3:0] req_lvl,
  input  wire logic       rst_lvl,
  input  wire logic       spike_ok,
  output logic      [3:0] req_pin,
  output logic            preset_pin_n
);
  int low_cnt = 0;

  initial req_pin = 4'h0;
  initial preset_pin_n = 1'h1;

  // A low pulse is stretched to 13 cycles so it always takes effect.
  // Only a scenario that wants a spike may release it earlier.
  always @(posedge clk)
  begin
    req_pin <= req_lvl;
    if (!rst_lvl || (!preset_pin_n && low_cnt < 13 && !spike_ok))
    begin
      preset_pin_n <= 1'h0;
      low_cnt      <= low_cnt + 1;
    end
    else
    begin
      preset_pin_n <= 1'h1;
      low_cnt      <= 0;
    end
  end
endmodule : periph_model

// ===== tb/tb_clock_request_decoder.sv
`timescale 1ns/10ps
`include "clock_request_decoder_consts.svh"
module tb_clock_request_decoder;
  logic                               clk = 1'h0;
  logic                               resetn = 1'h0;
  logic [3:0]                         req_lvl = 4'h0;
  logic                               rst_lvl = 1'h1;
  logic                               spike_ok = 1'h0;
  logic [3:0]                         req_pin;
  logic                               preset_pin_n;
  clock_request_pkg::supply_t         sup = 3'h7;
  clock_request_pkg::cfg_write_t      wr = '0;
  clock_request_pkg::sine_ctl_t [3:0] sc;
  logic                               mo;
  logic                               moe;
  logic                               reg_on;
  logic                               blk;
  logic [3:0]                         eff;
  logic [7:0]                         pol_m;
  logic [7:0]                         sw_m;
  logic [7:0]                         prio_m;
  bit                                 rst_m = 1'h0;
  int                                 num_errors = 0;
  int                                 n_tests = 0;

  always #20 clk = ~clk;

  periph_model u_periph (.clk(clk), .req_lvl(req_lvl), .rst_lvl(rst_lvl),
    .spike_ok(spike_ok), .req_pin(req_pin), .preset_pin_n(preset_pin_n));

  clock_request_decoder DUT (.clk(clk), .resetn(resetn),
    .peripheral_clock_request(req_pin), .preset_n_pin(preset_pin_n),
    .supply_pins(sup), .cfg_wr(wr), .sine_ctl(sc), .mclk_request_o(mo),
    .mclk_request_oe(moe), .oscillator_regulator_out(reg_on),
    .effective_request(eff), .cfg_blocked(blk));

  task automatic conclude;
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic defaults;
    pol_m  = `CRD_POL_RST;
    sw_m   = `CRD_SW_RST;
    prio_m = `CRD_PRIO_RST;
  endtask : defaults

  task automatic cfg(input logic [1:0] idx, input logic [7:0] d);
    @(posedge clk);
    wr <= '{en: 1'h1, idx: idx, data: d};
    @(posedge clk);
    wr.en <= 1'h0;
    if (!rst_m && idx == 2'h0) pol_m = d;
    if (!rst_m && idx == 2'h1) sw_m = d;
    if (!rst_m && idx == 2'h2) prio_m = d;
  endtask : cfg

  // Waits n edges, compares every output, and returns on a rising edge.
  task automatic check_all(input int n);
    logic [3:0] e;
    logic [3:0] gp;
    logic [3:0] gh;
    logic       any;
    logic       rg;
    logic       xo;
    logic       xoe;
    repeat (n) @(posedge clk);
    #1;
    e = (prio_m[3:0] & sw_m[3:0]) | (~prio_m[3:0] & (req_lvl ^ pol_m[3:0]));
    if (rst_m) e = e | 4'h9;
    any = |e;
    rg = (prio_m[4] ? prio_m[5] : (any | rst_m)) & sup.battery & sup.core;
    xo = 1'h1;
    xoe = any;
    if (sw_m[5:4] == 2'h1) {xo, xoe} = {1'h0, ~any};
    if (sw_m[5:4] == 2'h2) {xo, xoe} = {any, 1'h1};
    for (int i = 0; i < 4; i++)
    begin
      gp[i] = sc[i].pass & sup.buffer;
      gh[i] = sc[i].hiz;
    end
    chk({4'h0, eff}, {4'h0, e});
    chk({4'h0, gp}, {4'h0, e & {4{sup.buffer}}});
    chk({4'h0, gh}, {4'h0, {4{~sup.buffer}}});
    chk({6'h0, mo, moe}, {6'h0, xo, xoe});
    chk({7'h0, reg_on}, {7'h0, rg});
    chk({7'h0, blk}, {7'h0, rst_m});
    @(posedge clk);
  endtask : check_all

  initial
  begin
    #(40 * 5000);
    num_errors++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'h0FF24B59));
    defaults();
    repeat (4) @(posedge clk);
    resetn  <= 1'h1;
    req_lvl <= 4'($urandom);
    check_all(4);
    for (int i = 0; i < 60; i++)
    begin
      cfg(2'($urandom % 4), 8'($urandom));
      req_lvl    <= 4'($urandom);
      sup.buffer <= 1'($urandom);
      check_all(4);
    end
    sup.buffer <= 1'h1;
    cfg(2'h2, 8'h06);
    cfg(2'h1, 8'h16);
    req_lvl <= 4'h0;
    rst_lvl <= 1'h0;
    rst_m = 1'h1;
    sw_m = sw_m | 8'h09;
    prio_m = prio_m | 8'h09;
    check_all(13);
    cfg(2'h1, 8'h00);
    check_all(1);
    rst_lvl <= 1'h1;
    rst_m = 1'h0;
    check_all(14);
    // Clear the bits a false reset would set, so an accepted spike shows.
    cfg(2'h0, 8'h00);
    cfg(2'h1, 8'h00);
    cfg(2'h2, 8'h00);
    spike_ok <= 1'h1;
    rst_lvl  <= 1'h0;
    repeat (7) @(posedge clk);
    rst_lvl <= 1'h1;
    check_all(14);
    resetn <= 1'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    defaults();
    check_all(4);
    sup.battery <= 1'h0;
    check_all(4);
    sup.battery <= 1'h1;
    sup.core    <= 1'h0;
    check_all(4);
    sup.core <= 1'h1;
    check_all(4);
    conclude();
  end
endmodule : tb_clock_request_decoder
